// file: core/dil_pkg.sv
// constants for the serial controller interrupt logic
package dil_pkg;
    localparam int DW = 8;
    localparam int AW = 4;
    // register addresses
    localparam logic [3:0] ADDR_INPUT_CHANGE_REG = 4'h4;
    localparam logic [3:0] ADDR_ISR_IMR = 4'h5;
    localparam logic [3:0] ADDR_COUNTER_PRESET_UPPER = 4'h6;
    localparam logic [3:0] ADDR_VEC = 4'hC;
    localparam logic [3:0] ADDR_START = 4'hE;
    localparam logic [3:0] ADDR_STOP = 4'hF;
    // status and mask bit positions
    localparam int B_A_TX = 0;
    localparam int B_A_RX = 1;
    localparam int B_A_BRK = 2;
    localparam int B_CT = 3;
    localparam int B_B_TX = 4;
    localparam int B_B_RX = 5;
    localparam int B_B_BRK = 6;
    localparam int B_IPC = 7;
    // reset values
    localparam logic [7:0] VEC_RST = 8'h0F;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] COUNTER_PRESET_UPPER_RST = 8'h00;
    localparam logic [7:0] ZERO8 = 8'h00;
    // host pins seen through a two stage synchroniser
    typedef struct packed {
        logic [1:0] cs_n;
        logic [1:0] rd_n;
        logic [1:0] wr_n;
        logic [1:0] iack_n;
        logic [1:0] nvec;
        logic [1:0][3:0] addr;
        logic [1:0][7:0] din;
    } dil_sync_t;
endpackage

// file: core/dil_top.sv
// interrupt status, mask and vector logic of the dual serial controller
`timescale 1ns/1ns
module dil_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // host parallel bus pins
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [dil_pkg::AW-1:0] addr_i,
    input wire logic [dil_pkg::DW-1:0] data_i,
    output logic [dil_pkg::DW-1:0] data_o,
    output logic data_oe_n_o,
    input wire logic int_acknowledge_low_i,
    input wire logic nonvectored_i,
    output logic irq_out_low_o,
    // channel a events
    input wire logic chan_a_tx_irq_i,
    input wire logic chan_a_rx_irq_i,
    input wire logic chan_a_rx_wdog_i,
    input wire logic chan_a_brk_chg_i,
    input wire logic chan_a_brk_rst_i,
    // channel b events
    input wire logic chan_b_tx_irq_i,
    input wire logic chan_b_rx_irq_i,
    input wire logic chan_b_rx_wdog_i,
    input wire logic chan_b_brk_chg_i,
    input wire logic chan_b_brk_rst_i,
    // input port change
    input wire logic ip_change_i,
    input wire logic [dil_pkg::DW-1:0] input_change_reg_i,
    // counter/timer
    input wire logic ct_timer_mode_i,
    input wire logic ct_zero_i,
    output logic ct_start_o,
    output logic ct_stop_o,
    output logic [dil_pkg::DW-1:0] counter_preset_upper_o,
    // unmasked status for output port pins
    output logic [dil_pkg::DW-1:0] status_raw_o
);
    import dil_pkg::*;

    typedef struct packed {
        // host pins, two flops each
        dil_sync_t sy;
        // read seen last cycle, so a read acts once
        logic rd_act;
        // host written registers
        logic [7:0] mask;
        logic [7:0] counter_preset_upper;
        logic [7:0] vec;
        // sticky status flags and the square wave parity bit
        logic brk_a;
        logic brk_b;
        logic ct_rdy;
        logic ipc;
        logic half;
        // one cycle counter commands
        logic start;
        logic stop;
        // registered data bus drive
        logic [7:0] dout;
        logic drive;
    } dil_state_t;

    dil_state_t st_ff;
    dil_state_t nxt_st;

    // current values of the host pins after two flops
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic iack_s;
    logic nvec_s;
    logic [3:0] addr_s;
    logic [7:0] din_s;
    logic [7:0] status;
    logic rd_go;
    logic wr_go;
    logic rd_on;
    logic iack_on;
    // decoded one shot register strobes
    logic rd_input_change_reg;
    logic rd_start;
    logic rd_stop;
    logic wr_mask;
    logic wr_counter_preset_upper;
    logic wr_vec;
    // host read data chosen by address
    logic [7:0] rd_mux;
    // level requests shown straight in status
    logic a_tx_req;
    logic a_rx_req;
    logic b_tx_req;
    logic b_rx_req;
    // set and clear terms of the sticky flags
    logic ct_set;
    logic ct_clr;
    logic half_clr;
    logic half_flip;
    logic brk_a_set;
    logic brk_a_clr;
    logic brk_b_set;
    logic brk_b_clr;
    logic ipc_set;
    logic ipc_clr;

    // sticky flag helper: an event in the clear cycle still sets
    function automatic logic sticky(input logic cur, input logic set,
                                    input logic clr);
        sticky = set | (cur & ~clr);
    endfunction

    // address decode used for the read side effects and the write strobes
    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] want);
        hit = (a == want);
    endfunction

    // one step of a two flop pin synchroniser
    function automatic logic [1:0] sync2(input logic [1:0] cur,
                                         input logic pin);
        sync2 = {cur[0], pin};
    endfunction

    // true when any status bit meets a set mask bit
    function automatic logic any_enabled(input logic [7:0] stat,
                                         input logic [7:0] msk);
        any_enabled = |(stat & msk);
    endfunction

    // host read data by address; unmapped reads give zero
    function automatic logic [7:0] rd_pick(input logic [3:0] a,
                                           input logic [7:0] input_change_reg,
                                           input logic [7:0] stat,
                                           input logic [7:0] vec);
        case (a)
            ADDR_INPUT_CHANGE_REG: rd_pick = input_change_reg;
            ADDR_ISR_IMR: rd_pick = stat;
            ADDR_VEC: rd_pick = vec;
            default: rd_pick = ZERO8;
        endcase
    endfunction

    assign cs_s = st_ff.sy.cs_n[1];
    assign rd_s = st_ff.sy.rd_n[1];
    assign wr_s = st_ff.sy.wr_n[1];
    assign iack_s = st_ff.sy.iack_n[1];
    assign nvec_s = st_ff.sy.nvec[1];
    assign addr_s = st_ff.sy.addr[1];
    assign din_s = st_ff.sy.din[1];

    // status byte; request bits follow their sources
    always_comb begin
        status = ZERO8;
        status[B_A_TX] = a_tx_req;
        status[B_A_RX] = a_rx_req;
        status[B_A_BRK] = st_ff.brk_a;
        status[B_CT] = st_ff.ct_rdy;
        status[B_B_TX] = b_tx_req;
        status[B_B_RX] = b_rx_req;
        status[B_B_BRK] = st_ff.brk_b;
        status[B_IPC] = st_ff.ipc;
    end

    // bus strobes after synchronisation
    assign rd_on = ~cs_s & ~rd_s;
    assign rd_go = rd_on & ~st_ff.rd_act;
    // write is taken on the trailing edge, data is settled by then
    assign wr_go = ~cs_s & ~wr_s & st_ff.sy.wr_n[0];
    // acknowledge only matters in vectored mode
    assign iack_on = ~iack_s & ~nvec_s;

    // register strobes; reads act once per strobe
    assign rd_input_change_reg = rd_go & hit(addr_s, ADDR_INPUT_CHANGE_REG);
    assign rd_start = rd_go & hit(addr_s, ADDR_START);
    assign rd_stop = rd_go & hit(addr_s, ADDR_STOP);
    assign wr_mask = wr_go & hit(addr_s, ADDR_ISR_IMR);
    assign wr_counter_preset_upper = wr_go & hit(addr_s, ADDR_COUNTER_PRESET_UPPER);
    assign wr_vec = wr_go & hit(addr_s, ADDR_VEC);
    assign rd_mux = rd_pick(addr_s, input_change_reg_i, status, st_ff.vec);

    // level requests; a watchdog timeout also raises receive
    assign a_tx_req = chan_a_tx_irq_i;
    assign a_rx_req = chan_a_rx_irq_i | chan_a_rx_wdog_i;
    assign b_tx_req = chan_b_tx_irq_i;
    assign b_rx_req = chan_b_rx_irq_i | chan_b_rx_wdog_i;

    // counter ready: counter mode every zero, timer every second
    assign ct_set = ct_zero_i & (~ct_timer_mode_i | st_ff.half);
    assign ct_clr = rd_stop;
    // start restarts the square wave, so parity starts over
    assign half_clr = rd_start;
    assign half_flip = ct_zero_i & ct_timer_mode_i;

    // break change: only the reset break command clears
    assign brk_a_set = chan_a_brk_chg_i;
    assign brk_a_clr = chan_a_brk_rst_i;
    assign brk_b_set = chan_b_brk_chg_i;
    assign brk_b_clr = chan_b_brk_rst_i;

    // input change: cleared by reading the change register
    assign ipc_set = ip_change_i;
    assign ipc_clr = rd_input_change_reg;

    // next state
    always_comb begin
        nxt_st = st_ff;
        // two flop synchronisers for all host pins
        nxt_st.sy.cs_n = sync2(st_ff.sy.cs_n, cs_n_i);
        nxt_st.sy.rd_n = sync2(st_ff.sy.rd_n, rd_n_i);
        nxt_st.sy.wr_n = sync2(st_ff.sy.wr_n, wr_n_i);
        nxt_st.sy.iack_n = sync2(st_ff.sy.iack_n, int_acknowledge_low_i);
        nxt_st.sy.nvec = sync2(st_ff.sy.nvec, nonvectored_i);
        nxt_st.sy.addr = {st_ff.sy.addr[0], addr_i};
        nxt_st.sy.din = {st_ff.sy.din[0], data_i};
        nxt_st.rd_act = rd_on;
        nxt_st.start = 1'b0;
        nxt_st.stop = 1'b0;

        // register writes, taken once per strobe
        if (wr_mask) begin
            nxt_st.mask = din_s;
        end
        if (wr_counter_preset_upper) begin
            nxt_st.counter_preset_upper = din_s;
        end
        if (wr_vec) begin
            nxt_st.vec = din_s;
        end

        // counter commands are reads of the command addresses
        nxt_st.start = rd_start;
        nxt_st.stop = rd_stop;

        // square wave parity, restarted by a start command
        if (half_clr) begin
            nxt_st.half = 1'b0;
        end else if (half_flip) begin
            nxt_st.half = ~st_ff.half;
        end

        // sticky flags; an event in the clear cycle still sets
        nxt_st.ct_rdy = sticky(st_ff.ct_rdy, ct_set, ct_clr);
        nxt_st.brk_a = sticky(st_ff.brk_a, brk_a_set, brk_a_clr);
        nxt_st.brk_b = sticky(st_ff.brk_b, brk_b_set, brk_b_clr);
        nxt_st.ipc = sticky(st_ff.ipc, ipc_set, ipc_clr);

        // acknowledge wins over a read; status is never masked
        nxt_st.drive = rd_on | iack_on;
        if (iack_on) begin
            nxt_st.dout = st_ff.vec;
        end else if (rd_on) begin
            nxt_st.dout = rd_mux;
        end else begin
            nxt_st.dout = ZERO8;
        end
    end

    // state register; reset gives constants only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // strobes idle high, so no false access after reset
            st_ff.sy.cs_n <= '1;
            st_ff.sy.rd_n <= '1;
            st_ff.sy.wr_n <= '1;
            st_ff.sy.iack_n <= '1;
            st_ff.sy.nvec <= '0;
            st_ff.sy.addr <= '0;
            st_ff.sy.din <= '0;
            st_ff.rd_act <= 1'b0;
            // host registers
            st_ff.mask <= MASK_RST;
            st_ff.counter_preset_upper <= COUNTER_PRESET_UPPER_RST;
            st_ff.vec <= VEC_RST;
            // every sticky status flag starts clear
            st_ff.brk_a <= 1'b0;
            st_ff.brk_b <= 1'b0;
            st_ff.ct_rdy <= 1'b0;
            st_ff.ipc <= 1'b0;
            st_ff.half <= 1'b0;
            // command pulses and bus drive off
            st_ff.start <= 1'b0;
            st_ff.stop <= 1'b0;
            st_ff.dout <= ZERO8;
            st_ff.drive <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs; irq releases as soon as no enabled bit remains
    assign irq_out_low_o = ~any_enabled(status, st_ff.mask);
    // output pins see status before the mask
    assign status_raw_o = status;
    // data bus straight from flops, no glitches on the pins
    assign data_o = st_ff.dout;
    assign data_oe_n_o = ~st_ff.drive;
    // counter engine sees one cycle commands
    assign ct_start_o = st_ff.start;
    assign ct_stop_o = st_ff.stop;
    assign counter_preset_upper_o = st_ff.counter_preset_upper;
endmodule

// file: testbench/dil_chk.sv
// port checker for the interrupt logic
`timescale 1ns/1ns
module dil_chk (
    // watched ports
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic irq_out_low_o,
    input wire logic [7:0] status_raw_o,
    input wire logic chan_a_tx_irq_i,
    input wire logic chan_a_rx_irq_i,
    input wire logic chan_a_rx_wdog_i,
    input wire logic chan_b_tx_irq_i,
    input wire logic chan_a_brk_chg_i,
    input wire logic chan_a_brk_rst_i,
    input wire logic ct_zero_i,
    input wire logic ct_timer_mode_i,
    input wire logic ct_stop_o,
    input wire logic ct_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // stable request levels must show in status at the same edge
    property p_idle; status_raw_o == 8'h00 |-> irq_out_low_o; endproperty
    a_idle: assert property (p_idle) else $error("irq low");
    property p_src; !irq_out_low_o |-> status_raw_o != 8'h00; endproperty
    a_src: assert property (p_src) else $error("irq cause");
    property p_atx; $stable(chan_a_tx_irq_i) |->
        status_raw_o[0] == chan_a_tx_irq_i; endproperty
    a_atx: assert property (p_atx) else $error("a tx");
    property p_arx; $stable(chan_a_rx_irq_i | chan_a_rx_wdog_i) |->
        status_raw_o[1] == (chan_a_rx_irq_i | chan_a_rx_wdog_i); endproperty
    a_arx: assert property (p_arx) else $error("a rx");
    property p_btx; $stable(chan_b_tx_irq_i) |->
        status_raw_o[4] == chan_b_tx_irq_i; endproperty
    a_btx: assert property (p_btx) else $error("b tx");
    property p_brk; chan_a_brk_chg_i |=> status_raw_o[2]; endproperty
    a_brk: assert property (p_brk) else $error("brk set");
    property p_hold; status_raw_o[2] && !chan_a_brk_rst_i |=>
        status_raw_o[2]; endproperty
    a_hold: assert property (p_hold) else $error("brk hold");
    property p_ct; ct_zero_i && !ct_timer_mode_i |=> status_raw_o[3];
    endproperty
    a_ct: assert property (p_ct) else $error("ct set");
    property p_stop; $fell(status_raw_o[3]) |->
        ct_stop_o || $past(ct_stop_o); endproperty
    a_stop: assert property (p_stop) else $error("ct clear");
    property p_spulse; ct_start_o |=> !ct_start_o; endproperty
    a_spulse: assert property (p_spulse) else $error("start pulse");
endmodule

// file: testbench/dil_host.sv
// host processor model for the parallel register pins
`timescale 1ns/1ns
module dil_host (
    // clock
    input wire logic clk_i,
    // bus pins
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [3:0] addr_o,
    output logic [7:0] data_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
        addr_o = 4'h0;
        data_o = 8'h00;
    end
    // setup 2, strobe 5, gap 5 cycles: above the 3 cycle minimum
    task automatic acc(input logic [3:0] a, input logic [7:0] d,
                       input logic w, output logic [7:0] q);
        addr_o = a;
        data_o = d;
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b0;
        rd_n_o = w;
        wr_n_o = !w;
        repeat (5) @(negedge clk_i);
        q = rdata_i;
        {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
        data_o = ~d; // data inverted, no stale value left on the bus
        repeat (5) @(negedge clk_i);
    endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the interrupt logic
`timescale 1ns/1ns
module tb_top;
    import dil_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, ia = 1'b1, nv = 1'b0, tm = 1'b0;
    logic wd = 1'b0, ba = 1'b0, bb = 1'b0, cs, rd, wr, oe, irq;
    logic [7:0] ev = 8'h00, q, dout, din, st, pre;
    logic [3:0] ad;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #50 clk_i = ~clk_i;
    dil_host host (.clk_i(clk_i), .cs_n_o(cs), .rd_n_o(rd), .wr_n_o(wr),
        .addr_o(ad), .data_o(din), .rdata_i(dout));
    dil_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs), .rd_n_i(rd),
        .wr_n_i(wr), .addr_i(ad), .data_i(din), .data_o(dout),
        .data_oe_n_o(oe), .int_acknowledge_low_i(ia), .nonvectored_i(nv),
        .irq_out_low_o(irq), .chan_a_tx_irq_i(ev[0]),
        .chan_a_rx_irq_i(ev[1]), .chan_a_rx_wdog_i(wd),
        .chan_a_brk_chg_i(ev[2]), .chan_a_brk_rst_i(ba),
        .chan_b_tx_irq_i(ev[4]), .chan_b_rx_irq_i(ev[5]),
        .chan_b_rx_wdog_i(1'b0), .chan_b_brk_chg_i(ev[6]),
        .chan_b_brk_rst_i(bb), .ip_change_i(ev[7]),
        .input_change_reg_i(8'h96), .ct_timer_mode_i(tm),
        .ct_zero_i(ev[3]), .ct_start_o(), .ct_stop_o(),
        .counter_preset_upper_o(pre), .status_raw_o(st));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // hang guard, runs need about 290 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        t(6);
        rstn_i = 1'b1;
        t(2);
        chk(st, 8'h00);
        host.acc(ADDR_VEC, 8'h00, 1'b0, q);
        chk(q, 8'h0F);
        $display("reset test done");
        // each source alone, mask on its own position
        for (int i = 0; i < 8; i++) begin
            host.acc(ADDR_ISR_IMR, 8'h01 << i, 1'b1, q);
            ev = 8'h01 << i;
            t(1);
            ev = (i % 4 < 2) ? ev : 8'h00;
            t(1);
            chk(st, 8'h01 << i);
            chk(8'(irq), 8'h00);
            case (i)
                2: ba = 1'b1;
                3: host.acc(ADDR_STOP, 8'h00, 1'b0, q);
                6: bb = 1'b1;
                7: host.acc(ADDR_INPUT_CHANGE_REG, 8'h00, 1'b0, q);
                default: ev = 8'h00;
            endcase
            t(1);
            {ba, bb} = 2'b00;
            t(2);
            chk(st, 8'h00);
            chk(8'(irq), 8'h01);
        end
        host.acc(ADDR_ISR_IMR, 8'hFE, 1'b1, q);
        ev = 8'h01;
        t(2);
        chk(8'(irq), 8'h01);
        host.acc(ADDR_ISR_IMR, 8'h00, 1'b0, q);
        chk(q, 8'h01);
        wd = 1'b1;
        t(2);
        chk(st, 8'h03);
        {ev, wd} = 9'h000;
        $display("mask test done");
        tm = 1'b1;
        host.acc(ADDR_START, 8'h00, 1'b0, q);
        for (int k = 0; k < 2; k++) begin
            ev = 8'h08;
            t(1);
            ev = 8'h00;
            t(2);
            chk(st, {4'h0, k[0], 3'h0});
        end
        host.acc(ADDR_STOP, 8'h00, 1'b0, q);
        chk(st, 8'h00);
        host.acc(ADDR_VEC, 8'h5A, 1'b1, q);
        ia = 1'b0;
        t(4);
        chk(dout, 8'h5A);
        ia = 1'b1;
        nv = 1'b1;
        t(5);
        ia = 1'b0;
        t(4);
        chk(8'(oe), 8'h01);
        ia = 1'b1;
        host.acc(ADDR_COUNTER_PRESET_UPPER, 8'hA5, 1'b1, q);
        chk(pre, 8'hA5);
        host.acc(4'h9, 8'h00, 1'b0, q);
        chk(q, 8'h00);
        $display("vector test done");
        stop_test();
    end
endmodule
bind dil_top dil_chk u_chk (.clk_i, .rstn_i, .irq_out_low_o,
    .status_raw_o, .chan_a_tx_irq_i, .chan_a_rx_irq_i, .chan_a_rx_wdog_i,
    .chan_b_tx_irq_i, .chan_a_brk_chg_i, .chan_a_brk_rst_i, .ct_zero_i,
    .ct_timer_mode_i, .ct_stop_o, .ct_start_o);
